// File: verilog/flash_idle_read_defines.svh
// Offsets, field positions and command codes of the idle-read target logic.
// Assumes byte addressing on a 32-bit classic Wishbone bus.
`ifndef FLASH_IDLE_READ_DEFINES_SVH
`define FLASH_IDLE_READ_DEFINES_SVH
`define REG_CTRL      8'h00
`define REG_STAT      8'h04
`define REG_RESP      8'h08
`define CMD_CHG_COL   8'h05
`define CMD_CHG_COLE  8'h06
`define CMD_CACHE_SEQ 8'h31
`define CMD_CACHE_END 8'h3f
`define CMD_READ_ID   8'h90
`define CMD_GET_FEAT  8'hee
`define CMD_PARAM_PG  8'hec
`define CMD_UNIQUE_ID 8'hed
`define CMD_CONFIRM   8'he0
`define NUM_UNITS     4
`define COL_LAST_IDX  1'b1
`endif

// File: verilog/flash_idle_read_pkg.sv
// Types of the idle-read target logic: states, return states, exits and the state record.
// Assumes flash_idle_read_defines.svh is on the include path.
`include "flash_idle_read_defines.svh"
package flash_idle_read_pkg;
  typedef enum logic [4:0] {
    ST_IDLE_RD = 5'h00, ST_LUN_DATA = 5'h01, ST_XFER_HOST = 5'h03, ST_LUN_BYTE = 5'h02,
    ST_RD_STATUS = 5'h06, ST_STATUS_END = 5'h07, ST_XFER_BYTE = 5'h05, ST_CACHE = 5'h04,
    ST_WP_TR = 5'h0c, ST_RB_TR = 5'h0d, ST_CR_EXEC = 5'h0f, ST_CR_ADDR = 5'h0e,
    ST_CR_WAIT = 5'h0a, ST_CR_RET = 5'h0b, ST_CRE_EXEC = 5'h09, ST_CRE_COL = 5'h08,
    ST_AWAY = 5'h18
  } state_type;
  typedef enum logic [2:0] {
    RET_IDLE_RD = 3'h0, RET_IDLE = 3'h1, RET_RD_STATUS_OFF = 3'h2,
    RET_PP_ILV_WAIT = 3'h3, RET_OTHER = 3'h4
  } ret_type;
  typedef enum logic [2:0] {
    EXIT_RETURN = 3'h0, EXIT_DECODE = 3'h1, EXIT_COPYBACK = 3'h2,
    EXIT_PP_DATAOUT = 3'h3, EXIT_ROW_ADDR = 3'h4
  } exit_type;
  typedef struct packed {
    state_type   st;
    ret_type     ret;
    logic [7:0]  last_cmd;
    logic        f_status;
    logic        f_esr;
    logic        f_cc;
    logic        f_cce;
    logic        f_copy;
    logic        f_wide;
    logic [1:0]  unit;
    logic [7:0]  resp;
    logic        wp_seen;
    logic [3:0]  rb_seen;
    logic [15:0] col;
    logic        col_idx;
    logic [15:0] lun_word;
    logic [15:0] hd;
    logic        hv;
    logic [15:0] sd;
    logic        sv;
    logic        ready_busy;
    logic        wp_level;
    logic        st_req;
    logic        dt_req;
    logic        dt_wide;
    logic        cmd_valid;
    logic [7:0]  cmd_out;
    logic        col_sel;
    logic        exit_valid;
    exit_type    exit_tgt;
    logic        ack;
    logic [31:0] rdata;
  } regs_type;
endpackage

// File: verilog/flash_target_idle_read_fsm.sv
// Idle-read target logic of a flash device: read dispatch, cache commands, column change.
// Assumes host cycles and unit answers are synchronous to clk; a two-entry buffer feeds the host.
//
// What this block does
// (R1) Entering idle-read waits for requests and records idle-read as return state.
// (R2) A write-protect or unit-ready change in idle-read diverts to its handling first.
// (R3) Ready-busy output becomes the AND of all units' ready bits on that handling.
// (R4) Read with status output flag set requests a status byte and waits for it.
// (R5) The status byte goes to the host, then the return state is taken.
// (R6) Read after 90h or EEh outputs the next response byte, back to idle-read.
// (R7) Read after ECh or EDh fetches one byte from the unit page register first.
// (R8) Other reads with enhanced status not required fetch a byte or a word.
// (R9) With enhanced status required, any other read in idle-read is ignored; no unit is selected here.
// (R10) After data out: copyback, idle-read or the return state, by return and copyback.
// (R11) 05h with column change allowed starts column change and waits for address.
// (R12) 06h with enhanced column change allowed starts enhanced column change.
// (R13) 31h, or 3Fh after 31h, without enhanced status: record, pass to unit, idle-read.
// (R14) Any other command in idle-read goes to the general command decode.
// (R15) Column change stores column cycles until all arrive, then waits a command.
// (R16) Plain column change ends with E0h; data output resumes only after it.
// (R17) On confirm the unit selects the column; then data-out wait, idle-read or return.
// (R18) Enhanced column change stores column cycles, then goes on to row cycles.
`timescale 1ns/1ps
`default_nettype none
`include "flash_idle_read_defines.svh"
module flash_target_idle_read_fsm
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Host cycles.
  input  wire logic        cmd_cycle,
  input  wire logic        addr_cycle,
  input  wire logic [7:0]  cycle_byte,
  input  wire logic        read_req,
  input  wire logic        wp_n,
  output logic             ready_busy,
  // Data toward the host.
  output logic      [15:0] host_data,
  output logic             host_valid,
  input  wire logic        host_ready,
  // Units.
  input  wire logic [3:0]  unit_ready_bit,
  input  wire logic        unit_ack,
  input  wire logic [15:0] unit_data,
  output logic      [1:0]  unit_sel,
  output logic             unit_status_req,
  output logic             unit_data_req,
  output logic             unit_data_wide,
  output logic             unit_cmd_valid,
  output logic      [7:0]  unit_cmd,
  output logic             unit_col_select,
  output logic      [15:0] unit_col,
  output logic             unit_wp_level,
  // Hand-off to the surrounding target logic.
  input  wire logic        resume,
  output logic             exit_valid,
  output logic      [2:0]  exit_target,
  output logic      [2:0]  return_state_var
);
  flash_idle_read_pkg::regs_type s_q;
  flash_idle_read_pkg::regs_type s_d;
  logic quiet;

  // Queues a word for the host; callers first check that the spare entry is free.
  function automatic flash_idle_read_pkg::regs_type push(flash_idle_read_pkg::regs_type x,
                                                         logic [15:0] w);
    if (!x.hv)
    begin
      x.hd = w;
      x.hv = 1'b1;
    end
    else
    begin
      x.sd = w;
      x.sv = 1'b1;
    end
    return x;
  endfunction

  // Takes the recorded return state: stay here for idle-read, otherwise hand off.
  function automatic flash_idle_read_pkg::regs_type go_ret(flash_idle_read_pkg::regs_type x);
    if (x.ret == flash_idle_read_pkg::RET_IDLE_RD)
      x.st = flash_idle_read_pkg::ST_IDLE_RD;
    else
    begin
      x.st = flash_idle_read_pkg::ST_AWAY;
      x.exit_valid = 1'b1;
      x.exit_tgt = flash_idle_read_pkg::EXIT_RETURN;
    end
    return x;
  endfunction

  assign quiet = (wp_n == s_q.wp_seen) && (unit_ready_bit == s_q.rb_seen);

  always_comb
  begin
    s_d = s_q;
    s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
    s_d.cmd_valid = 1'b0;
    s_d.col_sel = 1'b0;
    s_d.exit_valid = 1'b0;
    if (s_d.ack)
    begin
      case (wb_adr_i)
        `REG_CTRL: s_d.rdata = {s_q.last_cmd, 8'h00, 1'b0, s_q.ret, 2'h0, s_q.unit,
                                2'h0, s_q.f_wide, s_q.f_copy, s_q.f_cce, s_q.f_cc,
                                s_q.f_esr, s_q.f_status};
        `REG_STAT: s_d.rdata = {s_q.col, 5'h00, s_q.sv, s_q.hv, s_q.ready_busy, 3'h0, s_q.st};
        `REG_RESP: s_d.rdata = {24'h000000, s_q.resp};
        default:   s_d.rdata = 32'h00000000;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && s_q.ack && wb_we_i)
    begin
      if (wb_adr_i == `REG_CTRL && wb_sel_i[0])
        {s_d.f_wide, s_d.f_copy, s_d.f_cce, s_d.f_cc, s_d.f_esr, s_d.f_status} = wb_dat_i[5:0];
      if (wb_adr_i == `REG_CTRL && wb_sel_i[1])
      begin
        s_d.unit = wb_dat_i[9:8];
        s_d.ret = flash_idle_read_pkg::ret_type'(wb_dat_i[14:12]);
      end
      if (wb_adr_i == `REG_CTRL && wb_sel_i[3])
        s_d.last_cmd = wb_dat_i[31:24];
      if (wb_adr_i == `REG_RESP && wb_sel_i[0])
        s_d.resp = wb_dat_i[7:0];
    end
    if (s_q.hv && host_ready)
    begin
      s_d.hd = s_q.sd;
      s_d.hv = s_q.sv;
      s_d.sv = 1'b0;
    end
    case (s_q.st)
      flash_idle_read_pkg::ST_IDLE_RD:
      begin
        if (wp_n != s_q.wp_seen)
          s_d.st = flash_idle_read_pkg::ST_WP_TR; // see (R2)
        else if (unit_ready_bit != s_q.rb_seen)
          s_d.st = flash_idle_read_pkg::ST_RB_TR; // see (R2)
        else if (read_req && s_q.f_status)
        begin
          s_d.st = flash_idle_read_pkg::ST_RD_STATUS; // see (R4)
          s_d.st_req = 1'b1;
        end
        else if (read_req && (s_q.last_cmd == `CMD_READ_ID || s_q.last_cmd == `CMD_GET_FEAT))
          s_d.st = flash_idle_read_pkg::ST_XFER_BYTE; // see (R6)
        else if (read_req &&
                 (s_q.last_cmd == `CMD_PARAM_PG || s_q.last_cmd == `CMD_UNIQUE_ID))
        begin
          s_d.st = flash_idle_read_pkg::ST_LUN_BYTE; // see (R7)
          s_d.dt_req = 1'b1;
          s_d.dt_wide = 1'b0;
        end
        else if (read_req && !s_q.f_esr)
        begin
          s_d.st = flash_idle_read_pkg::ST_LUN_DATA; // see (R8)
          s_d.dt_req = 1'b1;
          s_d.dt_wide = s_q.f_wide;
        end
        else if (cmd_cycle)
        begin
          s_d.col_idx = 1'b0;
          if (cycle_byte == `CMD_CHG_COL && s_q.f_cc)
            s_d.st = flash_idle_read_pkg::ST_CR_EXEC; // see (R11)
          else if (cycle_byte == `CMD_CHG_COLE && s_q.f_cce)
            s_d.st = flash_idle_read_pkg::ST_CRE_EXEC; // see (R12)
          else if (!s_q.f_esr && (cycle_byte == `CMD_CACHE_SEQ ||
                   (cycle_byte == `CMD_CACHE_END && s_q.last_cmd == `CMD_CACHE_SEQ)))
          begin
            s_d.st = flash_idle_read_pkg::ST_CACHE; // see (R13)
            s_d.cmd_out = cycle_byte;
          end
          else
          begin
            s_d.st = flash_idle_read_pkg::ST_AWAY; // see (R14)
            s_d.cmd_out = cycle_byte;
            s_d.exit_valid = 1'b1;
            s_d.exit_tgt = flash_idle_read_pkg::EXIT_DECODE;
          end
        end
      end
      flash_idle_read_pkg::ST_WP_TR:
      begin
        s_d.wp_level = wp_n;
        s_d.wp_seen = wp_n;
        s_d.st = flash_idle_read_pkg::ST_IDLE_RD;
      end
      flash_idle_read_pkg::ST_RB_TR:
      begin
        s_d.ready_busy = &unit_ready_bit; // see (R3)
        s_d.rb_seen = unit_ready_bit;
        s_d = go_ret(s_d);
      end
      flash_idle_read_pkg::ST_RD_STATUS:
        if (unit_ack)
        begin
          s_d.st_req = 1'b0;
          s_d.lun_word = {8'h00, unit_data[7:0]};
          s_d.st = flash_idle_read_pkg::ST_STATUS_END;
        end
      flash_idle_read_pkg::ST_STATUS_END:
        if (!s_d.sv)
        begin
          s_d = push(s_d, s_q.lun_word); // see (R5)
          s_d = go_ret(s_d);
        end
      flash_idle_read_pkg::ST_XFER_BYTE:
        if (!s_d.sv)
        begin
          s_d = push(s_d, {8'h00, s_q.resp}); // see (R6)
          s_d.st = flash_idle_read_pkg::ST_IDLE_RD;
        end
      flash_idle_read_pkg::ST_LUN_BYTE,
      flash_idle_read_pkg::ST_LUN_DATA:
        if (unit_ack)
        begin
          s_d.dt_req = 1'b0;
          s_d.lun_word = s_q.dt_wide ? unit_data : {8'h00, unit_data[7:0]};
          s_d.st = flash_idle_read_pkg::ST_XFER_HOST;
        end
      flash_idle_read_pkg::ST_XFER_HOST:
        if (!s_d.sv)
        begin
          s_d = push(s_d, s_q.lun_word);
          if (s_q.ret == flash_idle_read_pkg::RET_RD_STATUS_OFF && s_q.f_copy)
          begin
            s_d.st = flash_idle_read_pkg::ST_AWAY; // see (R10)
            s_d.exit_valid = 1'b1;
            s_d.exit_tgt = flash_idle_read_pkg::EXIT_COPYBACK;
          end
          else if (s_q.ret == flash_idle_read_pkg::RET_RD_STATUS_OFF)
            s_d.st = flash_idle_read_pkg::ST_IDLE_RD; // see (R10)
          else
            s_d = go_ret(s_d); // see (R10)
        end
      flash_idle_read_pkg::ST_CACHE:
      begin
        s_d.last_cmd = s_q.cmd_out; // see (R13)
        s_d.cmd_valid = 1'b1;
        s_d.st = flash_idle_read_pkg::ST_IDLE_RD;
      end
      flash_idle_read_pkg::ST_CR_EXEC,
      flash_idle_read_pkg::ST_CRE_EXEC:
        if (addr_cycle)
        begin
          if (s_q.col_idx)
            s_d.col[15:8] = cycle_byte; // see (R15)
          else
            s_d.col[7:0] = cycle_byte;
          s_d.st = (s_q.st == flash_idle_read_pkg::ST_CR_EXEC) ?
                   flash_idle_read_pkg::ST_CR_ADDR : flash_idle_read_pkg::ST_CRE_COL;
        end
      flash_idle_read_pkg::ST_CR_ADDR:
      begin
        s_d.col_idx = 1'b1;
        s_d.st = (s_q.col_idx == `COL_LAST_IDX) ? flash_idle_read_pkg::ST_CR_WAIT :
                 flash_idle_read_pkg::ST_CR_EXEC; // see (R15)
      end
      flash_idle_read_pkg::ST_CRE_COL:
      begin
        s_d.col_idx = 1'b1;
        if (s_q.col_idx == `COL_LAST_IDX)
        begin
          s_d.st = flash_idle_read_pkg::ST_AWAY; // see (R18)
          s_d.exit_valid = 1'b1;
          s_d.exit_tgt = flash_idle_read_pkg::EXIT_ROW_ADDR;
        end
        else
          s_d.st = flash_idle_read_pkg::ST_CRE_EXEC;
      end
      flash_idle_read_pkg::ST_CR_WAIT:
        if (cmd_cycle && cycle_byte == `CMD_CONFIRM)
          s_d.st = flash_idle_read_pkg::ST_CR_RET; // see (R16)
      flash_idle_read_pkg::ST_CR_RET:
      begin
        s_d.col_sel = 1'b1; // see (R17)
        if (s_q.ret == flash_idle_read_pkg::RET_PP_ILV_WAIT)
        begin
          s_d.st = flash_idle_read_pkg::ST_AWAY;
          s_d.exit_valid = 1'b1;
          s_d.exit_tgt = flash_idle_read_pkg::EXIT_PP_DATAOUT;
        end
        else if (s_q.ret == flash_idle_read_pkg::RET_RD_STATUS_OFF)
          s_d.st = flash_idle_read_pkg::ST_IDLE_RD;
        else
          s_d = go_ret(s_d);
      end
      flash_idle_read_pkg::ST_AWAY:
        if (resume)
          s_d.st = flash_idle_read_pkg::ST_IDLE_RD;
      default:
        s_d.st = flash_idle_read_pkg::ST_IDLE_RD;
    endcase
    if (s_d.st == flash_idle_read_pkg::ST_IDLE_RD && s_q.st != flash_idle_read_pkg::ST_IDLE_RD)
      s_d.ret = flash_idle_read_pkg::RET_IDLE_RD; // see (R1)
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign wb_dat_o         = s_q.rdata;
  assign wb_ack_o         = s_q.ack;
  assign ready_busy       = s_q.ready_busy;
  assign host_data        = s_q.hd;
  assign host_valid       = s_q.hv;
  assign unit_sel         = s_q.unit;
  assign unit_status_req  = s_q.st_req;
  assign unit_data_req    = s_q.dt_req;
  assign unit_data_wide   = s_q.dt_wide;
  assign unit_cmd_valid   = s_q.cmd_valid;
  assign unit_cmd         = s_q.cmd_out;
  assign unit_col_select  = s_q.col_sel;
  assign unit_col         = s_q.col;
  assign unit_wp_level    = s_q.wp_level;
  assign exit_valid       = s_q.exit_valid;
  assign exit_target      = s_q.exit_tgt;
  assign return_state_var = s_q.ret;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_entry_return: assert property ($changed(s_q.st) && s_q.st == flash_idle_read_pkg::ST_IDLE_RD
    |-> s_q.ret == flash_idle_read_pkg::RET_IDLE_RD) else $error("return state not idle-read"); // see (R1)
  a_wp_divert: assert property (s_q.st == flash_idle_read_pkg::ST_IDLE_RD && wp_n != s_q.wp_seen
    |=> s_q.st == flash_idle_read_pkg::ST_WP_TR ##1 unit_wp_level == $past(wp_n))
    else $error("write-protect change not handled"); // see (R2)
  a_ready_and: assert property (s_q.st == flash_idle_read_pkg::ST_RB_TR
    |=> ready_busy == &$past(unit_ready_bit)) else $error("ready-busy not AND of units"); // see (R3)
  a_status_req: assert property (s_q.st == flash_idle_read_pkg::ST_IDLE_RD && quiet && read_req
    && s_q.f_status |=> unit_status_req && s_q.st == flash_idle_read_pkg::ST_RD_STATUS)
    else $error("status not requested"); // see (R4)
  a_status_out: assert property (s_q.st == flash_idle_read_pkg::ST_STATUS_END && !s_q.sv
    |=> s_q.st != flash_idle_read_pkg::ST_STATUS_END && host_valid)
    else $error("status byte not sent"); // see (R5)
  a_id_byte: assert property (s_q.st == flash_idle_read_pkg::ST_XFER_BYTE && !s_q.sv
    |=> s_q.st == flash_idle_read_pkg::ST_IDLE_RD && host_valid) else $error("id byte lost"); // see (R6)
  a_byte_narrow: assert property (s_q.st == flash_idle_read_pkg::ST_LUN_BYTE
    |-> unit_data_req && !unit_data_wide) else $error("page byte fetch wrong"); // see (R7)
  a_data_width: assert property (s_q.st == flash_idle_read_pkg::ST_LUN_DATA
    |-> unit_data_req && unit_data_wide == s_q.f_wide) else $error("data width wrong"); // see (R8)
  a_copyback: assert property (s_q.st == flash_idle_read_pkg::ST_XFER_HOST && !s_q.sv && s_q.f_copy
    && s_q.ret == flash_idle_read_pkg::RET_RD_STATUS_OFF
    |=> exit_valid && exit_target == flash_idle_read_pkg::EXIT_COPYBACK)
    else $error("copyback not taken"); // see (R10)
  a_chg_col: assert property (s_q.st == flash_idle_read_pkg::ST_IDLE_RD && quiet && !read_req
    && cmd_cycle && cycle_byte == `CMD_CHG_COL && s_q.f_cc
    |=> s_q.st == flash_idle_read_pkg::ST_CR_EXEC) else $error("column change not begun"); // see (R11)
  a_cache_pass: assert property (s_q.st == flash_idle_read_pkg::ST_CACHE
    |=> unit_cmd_valid && s_q.last_cmd == unit_cmd && s_q.st == flash_idle_read_pkg::ST_IDLE_RD)
    else $error("cache command not passed"); // see (R13)
  a_wait_confirm: assert property (s_q.st == flash_idle_read_pkg::ST_CR_WAIT
    && !(cmd_cycle && cycle_byte == `CMD_CONFIRM) |=> s_q.st == flash_idle_read_pkg::ST_CR_WAIT)
    else $error("left wait without confirm"); // see (R16)
  a_col_select: assert property (s_q.st == flash_idle_read_pkg::ST_CR_RET
    |=> unit_col_select ##1 !unit_col_select) else $error("column select missing"); // see (R17)

  c_status_read: cover property (s_q.st == flash_idle_read_pkg::ST_STATUS_END ##1 host_valid);
  c_col_change: cover property (s_q.st == flash_idle_read_pkg::ST_CR_RET);
  c_buffer_full: cover property (s_q.sv && !host_ready);
endmodule
`default_nettype wire

// File: sim/unit_model.sv
// Behavioural model of the flash units behind the idle-read target logic.
// Assumes one clock shared with the design; each request is answered lag+1 cycles after it is raised.
`timescale 1ns/1ps
`default_nettype none
module unit_model
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Requests from the target logic.
  input  wire logic        status_req,
  input  wire logic        data_req,
  input  wire logic [3:0]  lag,
  // Answers.
  output logic             ack,
  output logic      [15:0] data
);
  logic [3:0] wait_q;
  // Between answers the data lines change every cycle, so a stale value never passes.
  always_ff @(posedge clk)
  begin
    ack  <= 1'b0;
    data <= ~data;
    if (rst)
    begin
      wait_q <= 4'h0;
      data   <= 16'h0000;
    end
    else if ((status_req || data_req) && !ack)
    begin
      if (wait_q >= lag)
      begin
        ack    <= 1'b1;
        data   <= status_req ? 16'h004e : 16'hc35a;
        wait_q <= 4'h0;
      end
      else
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench of the idle-read target logic with a unit model behind it.
// Assumes the design and unit_model are compiled first; registers go over classic Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "flash_idle_read_defines.svh"
module tb;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic        cmd = 1'b0, adc = 1'b0, rq = 1'b0, wp_n = 1'b0, hr = 1'b1, res = 1'b0;
  logic        rb, hv, uack, sreq, dreq, cv, csel, xv, ev_clr = 1'b0, dw, wpl, dw_s;
  logic [7:0]  adr = 8'h00, cb = 8'h00, ucmd, cmd_s;
  logic [3:0]  sel = 4'hf, urb = 4'h0, lag = 4'h0, ev = 4'h0;
  logic [31:0] wd = 32'h0, q, rdat;
  logic [15:0] hd, ud, ucol, col_s;
  logic [2:0]  xt, rsv, xt_s;
  logic [1:0]  usel;
  int          fails = 0, samples_checked = 0, cycles = 0, n;
  localparam logic [7:0]  ids [4] = '{`CMD_READ_ID, `CMD_GET_FEAT, `CMD_PARAM_PG, `CMD_UNIQUE_ID};
  localparam logic [15:0] drain [3] = '{16'h005a, 16'hc35a, 16'h005a};

  flash_target_idle_read_fsm i_flash_target_idle_read_fsm
  (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(q), .wb_ack_o(ack), .cmd_cycle(cmd),
    .addr_cycle(adc), .cycle_byte(cb), .read_req(rq), .wp_n(wp_n), .ready_busy(rb),
    .host_data(hd), .host_valid(hv), .host_ready(hr), .unit_ready_bit(urb), .unit_ack(uack),
    .unit_data(ud), .unit_sel(usel), .unit_status_req(sreq), .unit_data_req(dreq),
    .unit_data_wide(dw), .unit_cmd_valid(cv), .unit_cmd(ucmd), .unit_col_select(csel),
    .unit_col(ucol), .unit_wp_level(wpl), .resume(res), .exit_valid(xv), .exit_target(xt),
    .return_state_var(rsv)
  );
  unit_model i_unit_model
  (
    .clk(clk), .rst(rst), .status_req(sreq), .data_req(dreq), .lag(lag), .ack(uack),
    .data(ud)
  );

  always #10 clk = ~clk;

  // Pulse outputs are caught here so no scenario has to guess their cycle.
  always @(posedge clk)
  begin
    if (ev_clr) ev <= 4'h0;
    if (dreq === 1'b1) dw_s <= dw;
    if (csel === 1'b1) {ev[0], col_s} <= {1'b1, ucol};
    if (xv === 1'b1) {ev[1], xt_s} <= {1'b1, xt};
    if (cv === 1'b1) {ev[2], cmd_s} <= {1'b1, ucmd};
    if (hv === 1'b1) ev[3] <= 1'b1;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      final_report;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1);
    rdat = q;
    chk(n, 32'd2);
    {cyc, stb} <= 2'b00;
  endtask

  task ctrl(input logic [31:0] v);
    wb(1'b1, `REG_CTRL, v);
  endtask

  task start;
    for (int k = 0; k < 20; k++)
    begin
      wb(1'b0, `REG_STAT, 32'h0);
      if (rdat[4:0] === 5'h00) break;
    end
    chk({27'h0, rdat[4:0]}, 32'h0);
    ev_clr <= 1'b1;
    @(posedge clk);
    ev_clr <= 1'b0;
  endtask

  task pulse(input int kind, input logic [7:0] b);
    @(posedge clk);
    cb <= b;
    case (kind)
      0: cmd <= 1'b1;
      1: adc <= 1'b1;
      2: rq <= 1'b1;
      default: res <= 1'b1;
    endcase
    @(posedge clk);
    {cmd, adc, rq, res} <= 4'h0;
  endtask

  task wev(input logic [3:0] m);
    for (int k = 0; k < 40 && (ev & m) !== m; k++) @(negedge clk);
    chk({28'h0, ev & m}, {28'h0, m});
  endtask

  task rd(input logic [15:0] e);
    pulse(2, 8'h00);
    for (int k = 0; k < 40 && hv !== 1'b1; k++) @(negedge clk);
    chk({15'h0, hv, hd}, {15'h0, 1'b1, e});
  endtask

  task t_regs;
    chk({29'h0, rsv}, 32'h0);
    ctrl(32'h9000_0104);
    wb(1'b0, `REG_CTRL, 32'h0);
    chk(rdat, 32'h9000_0104);
    chk({30'h0, usel}, 32'h1);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    $display("test regs done");
  endtask

  task t_reads;
    start;
    ctrl(32'h1);
    lag <= 4'h5;
    rd(16'h004e);
    lag <= 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      start;
      ctrl({ids[i], 24'h20});
      wb(1'b1, `REG_RESP, 32'h3c);
      rd(i < 2 ? 16'h003c : 16'h005a);
      if (i >= 2) chk({31'h0, dw_s}, 32'h0);
    end
    start;
    ctrl(32'h20);
    rd(16'hc35a);
    chk({31'h0, dw_s}, 32'h1);
    start;
    ctrl(32'h0);
    rd(16'h005a);
    chk({31'h0, dw_s}, 32'h0);
    $display("test reads done");
  endtask

  task t_buffer;
    start;
    hr <= 1'b0;
    rd(16'h005a);
    start;
    ctrl(32'h20);
    pulse(2, 8'h00);
    start;
    ctrl(32'h0);
    pulse(2, 8'h00);
    hr <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk);
      for (int k = 0; k < 20 && hv !== 1'b1; k++) @(negedge clk);
      chk({15'h0, hv, hd}, {15'h0, 1'b1, drain[i]});
    end
    $display("test buffer done");
  endtask

  task t_column;
    start;
    ctrl(32'h0000_3004);
    pulse(0, `CMD_CHG_COL);
    pulse(1, 8'h34);
    pulse(1, 8'h12);
    pulse(0, 8'h70);
    repeat (4) @(posedge clk);
    chk({28'h0, ev}, 32'h0);
    pulse(0, `CMD_CONFIRM);
    wev(4'h3);
    chk({16'h0, col_s}, 32'h1234);
    chk({29'h0, xt_s}, 32'h3);
    pulse(3, 8'h00);
    start;
    ctrl(32'h8);
    pulse(0, `CMD_CHG_COLE);
    pulse(1, 8'h01);
    pulse(1, 8'h00);
    wev(4'h2);
    chk({29'h0, xt_s}, 32'h4);
    pulse(3, 8'h00);
    $display("test column done");
  endtask

  task t_cache;
    start;
    ctrl(32'h0);
    pulse(0, `CMD_CACHE_SEQ);
    wev(4'h4);
    chk({24'h0, cmd_s}, 32'h31);
    start;
    pulse(0, `CMD_CACHE_END);
    wev(4'h4);
    chk({24'h0, cmd_s}, 32'h3f);
    wb(1'b0, `REG_CTRL, 32'h0);
    chk({24'h0, rdat[31:24]}, 32'h3f);
    start;
    ctrl(32'h2);
    pulse(2, 8'h00);
    repeat (6) @(posedge clk);
    chk({31'h0, ev[3]}, 32'h0);
    wb(1'b0, `REG_STAT, 32'h0);
    chk({27'h0, rdat[4:0]}, 32'h0);
    pulse(0, `CMD_CACHE_SEQ);
    wev(4'h2);
    chk({29'h0, xt_s}, 32'h1);
    pulse(3, 8'h00);
    $display("test cache done");
  endtask

  task t_return;
    start;
    ctrl(32'h0000_2010);
    rd(16'h005a);
    wev(4'h2);
    chk({29'h0, xt_s}, 32'h2);
    pulse(3, 8'h00);
    start;
    ctrl(32'h0000_2000);
    rd(16'h005a);
    repeat (4) @(posedge clk);
    chk({31'h0, ev[1]}, 32'h0);
    start;
    wp_n <= 1'b1;
    urb <= 4'hf;
    start;
    start;
    chk({31'h0, wpl}, 32'h1);
    chk({31'h0, rb}, 32'h1);
    urb <= 4'h7;
    start;
    start;
    chk({31'h0, rb}, 32'h0);
    $display("test return done");
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_reads;
    t_buffer;
    t_column;
    t_cache;
    t_return;
    final_report;
  end
endmodule
`default_nettype wire
